// ---- design/cfl_logger.sv ----
// Counter flash logger: acquisition, page buffering, directory, download
//
// How it works
// - Array is 4096 blocks, 256 pages, 8KB.
// - Block zero directory; data from block one.
// - Defective blocks are never allocated.
// - Program only erased locations; erase first.
// - Fill page buffer, then program page.
// - Read page into buffer, stream from zero.
// - Nth file writes directory to page N-1.
// - 256 files max; then whole erase only.
// - File may use all blocks; halt when full.
// - Every new file starts a fresh block.
// - File size is blocks times 2MB.
// - Level mode counts gate high, stores falling.
// - Edge mode starts first falling edge, stores.
// - Append samples; stop at planned count.
// - Planned count 0-999999 times 1024, readable.
// - Files named by 8 chars; auto names.
// - Read style 0 raw, 1 ECC, 2 corrected.
// - Download by file name or block range.
// - Powers up stopped; start command begins.
// - Timer on-time in microseconds per sample.
// - Off-time zero means about 200ns.
// - Stop command halts counting immediately.
`timescale 1ns/1ps
module cfl_logger (
  input  wire logic                          mclk_i,
  input  wire logic                          resetn_i,
  input  wire logic                          gate_i,
  input  wire logic                          pulse_i,
  input  wire logic                          gate_level_store_start_i,
  input  wire logic                          gate_edge_store_start_i,
  input  wire logic                          timer_sync_store_start_i,
  input  wire logic                          stop_i,
  input  wire logic [cfl_pkg::TIME_W-1:0]    timer_on_time_i,
  input  wire logic [cfl_pkg::TIME_W-1:0]    timer_off_time_i,
  input  wire logic                          file_label_set_i,
  input  wire logic [cfl_pkg::LABEL_W-1:0]   file_label_i,
  input  wire logic                          planned_sample_count_set_i,
  input  wire logic [cfl_pkg::PLAN_W-1:0]    planned_sample_count_i,
  input  wire logic                          read_style_select_i,
  input  wire logic [1:0]                    read_style_i,
  input  wire logic                          whole_array_erase_i,
  input  wire logic                          directory_query_i,
  input  wire logic                          file_download_i,
  input  wire logic [cfl_pkg::LABEL_W-1:0]   download_label_i,
  input  wire logic                          block_range_download_i,
  input  wire logic [cfl_pkg::BLK_W-1:0]     range_first_i,
  input  wire logic [cfl_pkg::BLK_W-1:0]     range_last_i,
  input  wire logic                          bad_mark_i,
  input  wire logic [cfl_pkg::BLK_W-1:0]     bad_block_i,
  output logic                               flash_req_o,
  output cfl_pkg::cfl_fop_type               flash_op_o,
  output logic [cfl_pkg::BLK_W-1:0]          flash_block_o,
  output logic [cfl_pkg::PAGE_W-1:0]         flash_page_o,
  input  wire logic                          flash_ack_i,
  output logic                               flash_wvalid_o,
  output logic [31:0]                        flash_wdata_o,
  output logic                               flash_rd_o,
  input  wire logic                          flash_rvalid_i,
  input  wire logic [31:0]                   flash_rdata_i,
  output cfl_pkg::cfl_style_type             read_style_o,
  output logic                               dl_valid_o,
  output logic [31:0]                        dl_data_o,
  output logic                               dl_notfound_o,
  output logic [cfl_pkg::PLAN_W-1:0]         planned_sample_count_o,
  output logic [cfl_pkg::LABEL_W-1:0]        current_label_o,
  output logic [cfl_pkg::FCNT_W-1:0]         file_count_o,
  output logic                               dir_full_o,
  output logic                               acq_active_o
);
  import cfl_pkg::*;

  localparam logic [PRE_W-1:0]  PRE_LAST = PRE_W'(US_CYCLES - 1);
  localparam logic [PRE_W-1:0]  OFF_LAST = PRE_W'(OFF_ZERO_CYCLES - 1);
  localparam logic [WIDX_W-1:0] WLAST    = WIDX_W'(PAGE_WORDS - 1);
  localparam logic [PAGE_W-1:0] PG_LAST  = PAGE_W'(PAGES - 1);
  localparam logic [BLK_W:0]    NF_END   = (BLK_W+1)'(BLOCKS);

  logic [1:0] pins_s;
  logic       gate_s, pulse_s, gate_p_q, pulse_p_q;
  logic       gate_fall, pulse_rise;

  cfl_sync #(.WIDTH(2)) u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .d_i      ({gate_i, pulse_i}),
    .q_o      (pins_s)
  );
  assign gate_s     = pins_s[1];
  assign pulse_s    = pins_s[0];
  assign gate_fall  = gate_p_q & ~gate_s;
  assign pulse_rise = pulse_s & ~pulse_p_q;

  // Sampler state
  cfl_mode_type      mode_q;
  logic              run_q;
  logic [31:0]       cnt_q, cnt_d;
  logic              started_q, started_d, ph_off_q, ph_off_d;
  logic [PRE_W-1:0]  pre_q, pre_d;
  logic [TIME_W-1:0] tcnt_q, tcnt_d, on_q, off_q, on_last;
  logic              cap, counting, tick;

  assign tick    = pre_q == PRE_LAST;
  assign on_last = (on_q == '0) ? '0 : on_q - 1'b1;

  always_comb begin
    cnt_d = cnt_q;
    started_d = started_q;
    ph_off_d = ph_off_q;
    pre_d = pre_q;
    tcnt_d = tcnt_q;
    cap = 1'b0;
    counting = 1'b0;
    if (!run_q) begin
      started_d = 1'b0;
      ph_off_d = 1'b0;
      pre_d = '0;
      tcnt_d = '0;
      cnt_d = '0;
    end else begin
      unique case (mode_q)
        MODE_LEVEL: begin
          counting = gate_s;
          cap = gate_fall;
        end
        MODE_EDGE: begin
          counting = started_q;
          cap = started_q & gate_fall;
          if (gate_fall) started_d = 1'b1;
        end
        MODE_TIMER: begin
          counting = !ph_off_q;
          pre_d = tick ? '0 : pre_q + 1'b1;
          if (!ph_off_q) begin
            if (tick) begin
              tcnt_d = tcnt_q + 1'b1;
              if (tcnt_q == on_last) begin
                cap = 1'b1;
                ph_off_d = 1'b1;
                tcnt_d = '0;
              end
            end
          end else if (off_q == '0) begin
            if (pre_q == OFF_LAST) begin
              ph_off_d = 1'b0;
              pre_d = '0;
            end
          end else if (tick) begin
            tcnt_d = tcnt_q + 1'b1;
            if (tcnt_q == off_q - 1'b1) begin
              ph_off_d = 1'b0;
              tcnt_d = '0;
            end
          end
        end
        default: ;
      endcase
      if (counting && pulse_rise) cnt_d = cnt_q + 1'b1;
      if (cap) cnt_d = '0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
      started_q <= 1'b0;
      ph_off_q <= 1'b0;
      pre_q <= '0;
      tcnt_q <= '0;
      gate_p_q <= 1'b0;
      pulse_p_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      started_q <= started_d;
      ph_off_q <= ph_off_d;
      pre_q <= pre_d;
      tcnt_q <= tcnt_d;
      gate_p_q <= gate_s;
      pulse_p_q <= pulse_s;
    end
  end

  // Block tables and directory copy kept in registers
  logic               bad_q [BLOCKS];
  logic [LABEL_W-1:0] dir_name_q [MAX_FILES];
  logic [BLK_W-1:0]   dir_start_q [MAX_FILES];
  logic [BLK_W-1:0]   dir_last_q [MAX_FILES];
  logic [BLK_W:0]     dir_nblk_q [MAX_FILES];

  // Controller state
  cfl_state_type        st_q, st_d;
  cfl_mode_type         mode_d;
  cfl_style_type        style_q, style_d;
  logic                 run_d, acq_q, acq_d, fin_q, fin_d, pend_q, pend_d;
  logic [31:0]          sample_q, sample_d, wdata_q, wdata_d;
  logic                 wvalid_q, wvalid_d, dlv_q, dlv_d, miss_q, miss_d;
  logic [31:0]          dld_q, dld_d;
  logic [TIME_W-1:0]    on_d, off_d;
  logic [PLAN_W-1:0]    plan_q, plan_d;
  logic [DONE_W-1:0]    done_q, done_d;
  logic [LABEL_W-1:0]   label_q, label_d, eff_label;
  logic                 given_q, given_d;
  logic [11:0]          seq_q, seq_d;
  logic [FCNT_W-1:0]    fc_q, fc_d;
  logic [BLK_W:0]       nf_q, nf_d, nblk_q, nblk_d;
  logic [BLK_W-1:0]     blk_q, blk_d, fstart_q, fstart_d, hi_q, hi_d;
  logic [PAGE_W-1:0]    pg_q, pg_d, pglo_q, pglo_d, pghi_q, pghi_d;
  logic [WIDX_W-1:0]    widx_q, widx_d, wend_q, wend_d;
  logic [DIDX_W-1:0]    didx_q, didx_d;
  logic                 req_q, req_d, dir_wr;
  cfl_fop_type          op_q, op_d;
  logic [FCNT_W-2:0]    dent;
  logic                 can_start;

  assign eff_label = given_q ? label_q : {AUTO_PREFIX,
      ASCII_ZERO + {4'h0, seq_q[11:8]}, ASCII_ZERO + {4'h0, seq_q[7:4]},
      ASCII_ZERO + {4'h0, seq_q[3:0]}};
  assign dent = didx_q[FCNT_W:2];
  assign can_start = fc_q != FCNT_W'(MAX_FILES);

  function automatic logic [11:0] bcd_inc(input logic [11:0] v);
    logic [11:0] r;
    r = v;
    if (r[3:0] != 4'h9) r[3:0] = r[3:0] + 4'h1;
    else begin
      r[3:0] = 4'h0;
      if (r[7:4] != 4'h9) r[7:4] = r[7:4] + 4'h1;
      else begin
        r[7:4] = 4'h0;
        r[11:8] = r[11:8] + 4'h1;
      end
    end
    return r;
  endfunction : bcd_inc

  always_comb begin
    st_d = st_q; mode_d = mode_q; style_d = style_q; run_d = run_q;
    acq_d = acq_q; fin_d = fin_q; sample_d = sample_q; wdata_d = wdata_q;
    wvalid_d = 1'b0; dlv_d = 1'b0; dld_d = dld_q; miss_d = miss_q;
    on_d = on_q; off_d = off_q; plan_d = plan_q; done_d = done_q;
    label_d = label_q; given_d = given_q; seq_d = seq_q; fc_d = fc_q;
    nf_d = nf_q; nblk_d = nblk_q; blk_d = blk_q; fstart_d = fstart_q;
    hi_d = hi_q; pg_d = pg_q; pglo_d = pglo_q; pghi_d = pghi_q;
    widx_d = widx_q; wend_d = wend_q; didx_d = didx_q;
    req_d = req_q; op_d = op_q; dir_wr = 1'b0;
    // A sample landing as the previous one is consumed is kept
    pend_d = pend_q;
    if (file_label_set_i) begin
      label_d = file_label_i;
      given_d = 1'b1;
    end
    if (planned_sample_count_set_i)
      plan_d = (planned_sample_count_i > PLAN_MAX) ? PLAN_MAX
                                                   : planned_sample_count_i;
    if (read_style_select_i && read_style_i <= 2'(STYLE_FIXED))
      style_d = cfl_style_type'(read_style_i);
    if (stop_i && run_q) begin
      run_d = 1'b0;
      fin_d = 1'b1;
    end
    unique case (st_q)
      ST_IDLE: begin
        miss_d = miss_q & ~(directory_query_i | file_download_i
                            | block_range_download_i);
        if ((gate_level_store_start_i | gate_edge_store_start_i
             | timer_sync_store_start_i) && can_start) begin
          mode_d = gate_level_store_start_i ? MODE_LEVEL
                 : gate_edge_store_start_i ? MODE_EDGE : MODE_TIMER;
          on_d = timer_on_time_i;
          off_d = timer_off_time_i;
          acq_d = 1'b1;
          fin_d = 1'b0;
          pend_d = 1'b0;
          done_d = '0;
          nblk_d = '0;
          st_d = ST_NEXT;
        end else if (whole_array_erase_i) begin
          blk_d = DIR_BLOCK;
          op_d = FOP_ERASE;
          st_d = ST_ERASE;
        end else if (directory_query_i && fc_q != '0) begin
          blk_d = DIR_BLOCK;
          hi_d = DIR_BLOCK;
          pglo_d = PAGE_W'(fc_q - 1'b1);
          pghi_d = PAGE_W'(fc_q - 1'b1);
          wend_d = WIDX_W'({fc_q, 2'b00} - 1'b1);
          st_d = ST_RDLD;
        end else if (file_download_i) begin
          didx_d = '0;
          st_d = ST_SRCH;
        end else if (block_range_download_i && range_first_i <= range_last_i)
        begin
          blk_d = range_first_i;
          hi_d = range_last_i;
          pglo_d = '0;
          pghi_d = PG_LAST;
          wend_d = WLAST;
          st_d = ST_RDLD;
        end
        pg_d = pglo_d;
      end
      ST_NEXT: begin
        if (nf_q == NF_END) begin
          run_d = 1'b0;
          fin_d = 1'b1;
          if (nblk_q == '0) begin
            acq_d = 1'b0;
            st_d = ST_IDLE;
          end else begin
            didx_d = '0;
            dir_wr = 1'b1;
            st_d = ST_DIRW;
          end
        end else if (bad_q[nf_q[BLK_W-1:0]]) begin
          nf_d = nf_q + 1'b1;
        end else begin
          blk_d = nf_q[BLK_W-1:0];
          if (nblk_q == '0) begin
            fstart_d = nf_q[BLK_W-1:0];
            run_d = !fin_q;
          end
          nf_d = nf_q + 1'b1;
          nblk_d = nblk_q + 1'b1;
          pg_d = '0;
          widx_d = '0;
          st_d = ST_ARM;
        end
      end
      ST_ARM: begin
        if (pend_q) begin
          wvalid_d = 1'b1;
          wdata_d = sample_q;
          pend_d = 1'b0;
          done_d = done_q + 1'b1;
          widx_d = widx_q + 1'b1;
          if (widx_q == WLAST) begin
            op_d = FOP_PROG;
            st_d = ST_PROG;
          end
        end else if (fin_q || done_q == {plan_q, SAMPLE_UNIT_LOG2'(0)}) begin
          run_d = 1'b0;
          fin_d = 1'b1;
          op_d = FOP_PROG;
          if (widx_q != '0) st_d = ST_PROG;
          else begin
            didx_d = '0;
            dir_wr = 1'b1;
            st_d = ST_DIRW;
          end
        end
      end
      ST_PROG: begin
        req_d = 1'b1;
        if (flash_ack_i) begin
          req_d = 1'b0;
          widx_d = '0;
          pg_d = pg_q + 1'b1;
          if (fin_q) begin
            didx_d = '0;
            dir_wr = 1'b1;
            st_d = ST_DIRW;
          end else if (pg_q == PG_LAST) st_d = ST_NEXT;
          else st_d = ST_ARM;
        end
      end
      ST_DIRW: begin
        wvalid_d = 1'b1;
        unique case (didx_q[1:0])
          2'h0: wdata_d = dir_name_q[dent][63:32];
          2'h1: wdata_d = dir_name_q[dent][31:0];
          2'h2: wdata_d = {4'h0, dir_start_q[dent], 4'h0, dir_last_q[dent]};
          default: wdata_d = 32'(dir_nblk_q[dent]) * BLOCK_SIZE_MB;
        endcase
        didx_d = didx_q + 1'b1;
        if (dent == fc_q[FCNT_W-2:0] && didx_q[1:0] == 2'h3) begin
          blk_d = DIR_BLOCK;
          pg_d = fc_q[PAGE_W-1:0];
          op_d = FOP_PROG;
          st_d = ST_DIRP;
        end
      end
      ST_DIRP: begin
        req_d = 1'b1;
        if (flash_ack_i) begin
          req_d = 1'b0;
          fc_d = fc_q + 1'b1;
          given_d = 1'b0;
          seq_d = bcd_inc(seq_q);
          acq_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      ST_ERASE: begin
        req_d = !bad_q[blk_q] && !flash_ack_i;
        if (bad_q[blk_q] || flash_ack_i) begin
          blk_d = blk_q + 1'b1;
          if (blk_q == BLK_W'(BLOCKS - 1)) begin
            fc_d = '0;
            nf_d = {1'b0, FIRST_DATA_BLOCK};
            st_d = ST_IDLE;
          end
        end
      end
      ST_SRCH: begin
        if (didx_q[FCNT_W-1:0] == fc_q) begin
          miss_d = 1'b1;
          st_d = ST_IDLE;
        end else if (dir_name_q[didx_q[FCNT_W-2:0]] == download_label_i)
        begin
          blk_d = dir_start_q[didx_q[FCNT_W-2:0]];
          hi_d = dir_last_q[didx_q[FCNT_W-2:0]];
          pglo_d = '0;
          pg_d = '0;
          pghi_d = PG_LAST;
          wend_d = WLAST;
          st_d = ST_RDLD;
        end else didx_d = didx_q + 1'b1;
      end
      ST_RDLD: begin
        op_d = FOP_READ;
        req_d = !bad_q[blk_q] || blk_q == DIR_BLOCK;
        if (!req_d) begin
          blk_d = blk_q + 1'b1;
          if (blk_q == hi_q) st_d = ST_IDLE;
        end else if (flash_ack_i) begin
          req_d = 1'b0;
          widx_d = '0;
          st_d = ST_RDST;
        end
      end
      ST_RDST: begin
        if (flash_rvalid_i) begin
          dlv_d = 1'b1;
          dld_d = flash_rdata_i;
          widx_d = widx_q + 1'b1;
          if (widx_q == wend_q) begin
            pg_d = pg_q + 1'b1;
            st_d = ST_RDLD;
            if (pg_q == pghi_q) begin
              pg_d = pglo_q;
              blk_d = blk_q + 1'b1;
              if (blk_q == hi_q) st_d = ST_IDLE;
            end
          end
        end
      end
      default: st_d = ST_IDLE;
    endcase
    if (cap) begin
      pend_d = 1'b1;
      sample_d = cnt_q;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= ST_IDLE; mode_q <= MODE_LEVEL; style_q <= STYLE_RAW;
      run_q <= 1'b0; acq_q <= 1'b0; fin_q <= 1'b0; pend_q <= 1'b0;
      sample_q <= '0; wdata_q <= '0; wvalid_q <= 1'b0; dlv_q <= 1'b0;
      dld_q <= '0; miss_q <= 1'b0; on_q <= '0; off_q <= '0; plan_q <= '0;
      done_q <= '0; label_q <= '0; given_q <= 1'b0; seq_q <= AUTO_FIRST;
      fc_q <= '0; nf_q <= {1'b0, FIRST_DATA_BLOCK}; nblk_q <= '0;
      blk_q <= '0; fstart_q <= '0; hi_q <= '0; pg_q <= '0; pglo_q <= '0;
      pghi_q <= '0; widx_q <= '0; wend_q <= '0; didx_q <= '0;
      req_q <= 1'b0; op_q <= FOP_READ;
    end else begin
      st_q <= st_d; mode_q <= mode_d; style_q <= style_d;
      run_q <= run_d; acq_q <= acq_d; fin_q <= fin_d; pend_q <= pend_d;
      sample_q <= sample_d; wdata_q <= wdata_d; wvalid_q <= wvalid_d;
      dlv_q <= dlv_d; dld_q <= dld_d; miss_q <= miss_d; on_q <= on_d;
      off_q <= off_d; plan_q <= plan_d; done_q <= done_d;
      label_q <= label_d; given_q <= given_d; seq_q <= seq_d;
      fc_q <= fc_d; nf_q <= nf_d; nblk_q <= nblk_d; blk_q <= blk_d;
      fstart_q <= fstart_d; hi_q <= hi_d; pg_q <= pg_d; pglo_q <= pglo_d;
      pghi_q <= pghi_d; widx_q <= widx_d; wend_q <= wend_d;
      didx_q <= didx_d; req_q <= req_d; op_q <= op_d;
    end
  end

  // Bad marks survive an array erase; only reset clears them
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < BLOCKS; i++) bad_q[i] <= 1'b0;
    end else if (bad_mark_i && bad_block_i != DIR_BLOCK) begin
      bad_q[bad_block_i] <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (dir_wr) begin
      dir_name_q[fc_q[FCNT_W-2:0]] <= eff_label;
      dir_start_q[fc_q[FCNT_W-2:0]] <= fstart_q;
      dir_last_q[fc_q[FCNT_W-2:0]] <= blk_q;
      dir_nblk_q[fc_q[FCNT_W-2:0]] <= nblk_q;
    end
  end

  assign flash_req_o            = req_q;
  assign flash_op_o             = op_q;
  assign flash_block_o          = blk_q;
  assign flash_page_o           = pg_q;
  assign flash_wvalid_o         = wvalid_q;
  assign flash_wdata_o          = wdata_q;
  assign flash_rd_o             = st_q == ST_RDST;
  assign read_style_o           = style_q;
  assign dl_valid_o             = dlv_q;
  assign dl_data_o              = dld_q;
  assign dl_notfound_o          = miss_q;
  assign planned_sample_count_o = plan_q;
  assign current_label_o        = eff_label;
  assign file_count_o           = fc_q;
  assign dir_full_o             = !can_start;
  assign acq_active_o           = acq_q;
endmodule : cfl_logger

// ---- design/cfl_pkg.sv ----
// Shared constants and types for the counter flash logger
package cfl_pkg;
  localparam int BLOCKS          = 4096;
  localparam int PAGES           = 256;
  localparam int PAGE_BYTES      = 8192;
  localparam int WORD_BYTES      = 4;
  localparam int PAGE_WORDS      = PAGE_BYTES / WORD_BYTES;
  localparam int BLK_W           = 12;
  localparam int PAGE_W          = 8;
  localparam int WIDX_W          = 11;
  localparam int MAX_FILES       = 256;
  localparam int FCNT_W          = 9;
  localparam int DIR_ENTRY_WORDS = 4;
  localparam int DIDX_W          = 11;
  localparam int PLAN_W          = 20;
  localparam int SAMPLE_UNIT_LOG2 = 10;
  localparam int DONE_W          = PLAN_W + SAMPLE_UNIT_LOG2;
  localparam int BLOCK_SIZE_MB   = 2;
  localparam int LABEL_W         = 64;
  localparam int TIME_W          = 32;
  localparam int CLK_HZ          = 40_000_000;
  localparam int US_CYCLES       = CLK_HZ / 1_000_000;
  localparam int OFF_ZERO_NS     = 200;
  localparam int OFF_ZERO_CYCLES = (OFF_ZERO_NS * US_CYCLES) / 1000;
  localparam int PRE_W           = 6;

  localparam logic [PLAN_W-1:0] PLAN_MAX         = 20'hf423f;
  localparam logic [BLK_W-1:0]  DIR_BLOCK        = 12'h000;
  localparam logic [BLK_W-1:0]  FIRST_DATA_BLOCK = 12'h001;
  localparam logic [39:0]       AUTO_PREFIX      = 40'h646174615f;
  localparam logic [7:0]        ASCII_ZERO       = 8'h30;
  localparam logic [11:0]       AUTO_FIRST       = 12'h001;

  typedef enum logic [1:0] {
    STYLE_RAW   = 2'h0,
    STYLE_ECC   = 2'h1,
    STYLE_FIXED = 2'h2
  } cfl_style_type;

  typedef enum logic [1:0] {
    FOP_READ  = 2'h0,
    FOP_PROG  = 2'h1,
    FOP_ERASE = 2'h2
  } cfl_fop_type;

  typedef enum logic [1:0] {
    MODE_LEVEL = 2'h0,
    MODE_EDGE  = 2'h1,
    MODE_TIMER = 2'h2
  } cfl_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_NEXT  = 4'h1,
    ST_ARM   = 4'h3,
    ST_PROG  = 4'h2,
    ST_DIRW  = 4'h6,
    ST_DIRP  = 4'h7,
    ST_ERASE = 4'h5,
    ST_SRCH  = 4'h4,
    ST_RDLD  = 4'hc,
    ST_RDST  = 4'hd
  } cfl_state_type;
endpackage : cfl_pkg

// ---- design/cfl_sync.sv ----
// Two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module cfl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : cfl_sync

// ---- test/cfl_logger_assertions.sv ----
// Checker on the logger's flash, command and status ports
`timescale 1ns/1ps
module cfl_logger_assertions import cfl_pkg::*; (
  input wire logic mclk_i, resetn_i, flash_req_o, flash_ack_i,
  input wire logic flash_wvalid_o, acq_active_o, dir_full_o,
  input wire logic gate_level_store_start_i, read_style_select_i,
  input wire logic [1:0] read_style_i,
  input wire cfl_style_type read_style_o,
  input wire cfl_fop_type flash_op_o,
  input wire logic [BLK_W-1:0] flash_block_o,
  input wire logic [PAGE_W-1:0] flash_page_o,
  input wire logic planned_sample_count_set_i,
  input wire logic [PLAN_W-1:0] planned_sample_count_i,
  input wire logic [PLAN_W-1:0] planned_sample_count_o,
  input wire logic [FCNT_W-1:0] file_count_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wait; flash_req_o && !flash_ack_i; endsequence
  sequence s_ack; flash_req_o && flash_ack_i; endsequence
  property p_hold;
    s_wait |=> flash_req_o && $stable({flash_op_o, flash_block_o});
  endproperty
  property p_drop; s_ack |=> !flash_req_o; endproperty
  property p_style;
    read_style_select_i && read_style_i != 2'h3
      |=> read_style_o == $past(read_style_i);
  endproperty
  property p_plan;
    planned_sample_count_set_i && planned_sample_count_i <= PLAN_MAX
      |=> planned_sample_count_o == $past(planned_sample_count_i);
  endproperty
  property p_start;
    gate_level_store_start_i && !acq_active_o && !dir_full_o
      && !flash_req_o |=> acq_active_o;
  endproperty
  property p_full; dir_full_o |-> file_count_o == 9'h100; endproperty
  property p_push; flash_wvalid_o |-> acq_active_o; endproperty
  property p_refuse;
    dir_full_o && gate_level_store_start_i && !acq_active_o |=> !acq_active_o;
  endproperty
  a_hold: assert property (p_hold) else $error("flash request moved");
  a_drop: assert property (p_drop) else $error("request kept after ack");
  a_style: assert property (p_style) else $error("read style lost");
  a_plan: assert property (p_plan) else $error("planned count lost");
  a_start: assert property (p_start) else $error("start not taken");
  a_full: assert property (p_full) else $error("full flag wrong");
  a_push: assert property (p_push) else $error("word pushed idle");
  a_refuse: assert property (p_refuse) else $error("start when full");
endmodule : cfl_logger_assertions
bind cfl_logger cfl_logger_assertions cfl_logger_assertions_i (.*);

// ---- test/cfl_flash_model.sv ----
// Behavioural flash array with random operation latency
`timescale 1ns/1ps
module cfl_flash_model (
  input  wire logic  mclk_i, resetn_i, req_i, rd_i,
  output logic        ack_o, rvalid_o,
  output logic [31:0] rdata_o
);
  // Words change every cycle so a stale sample never looks valid
  assign rvalid_o = rd_i && resetn_i;
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req_i && !ack_o && ($urandom % 3 == 0);
    end
    rdata_o <= $urandom;
  end
endmodule : cfl_flash_model

// ---- test/tb.sv ----
// Self-checking testbench for the counter flash logger
`timescale 1ns/1ps
module tb;
  import cfl_pkg::*;
  logic mclk_i = 0, resetn_i = 0, gate_i = 0, pulse_i = 0, stop_i = 0;
  logic gate_level_store_start_i = 0, gate_edge_store_start_i = 0;
  logic timer_sync_store_start_i = 0, file_label_set_i = 0, bad_mark_i = 0;
  logic planned_sample_count_set_i = 0, read_style_select_i = 0;
  logic whole_array_erase_i = 0, directory_query_i = 0, file_download_i = 0;
  logic block_range_download_i = 0, flash_ack_i, flash_rvalid_i;
  logic flash_req_o, flash_wvalid_o, flash_rd_o, dl_valid_o, dl_notfound_o;
  logic dir_full_o, acq_active_o;
  logic [1:0] read_style_i = 0;
  logic [11:0] range_first_i = 0, range_last_i = 0, bad_block_i = 0;
  logic [11:0] flash_block_o;
  logic [7:0] flash_page_o;
  logic [19:0] planned_sample_count_i = 0, planned_sample_count_o;
  logic [31:0] timer_on_time_i = 0, timer_off_time_i = 0, flash_wdata_o;
  logic [31:0] flash_rdata_i, dl_data_o, d[$];
  logic [63:0] file_label_i = 0, download_label_i = 0, current_label_o;
  logic [8:0] file_count_o;
  cfl_fop_type flash_op_o;
  cfl_style_type read_style_o;
  logic [21:0] q[$];
  int n_errors = 0, n_compared = 0;
  always #12.5 mclk_i = ~mclk_i;
  cfl_logger cfl_logger_i (.*);
  cfl_flash_model cfl_flash_model_i (.mclk_i, .resetn_i, .req_i(flash_req_o),
    .rd_i(flash_rd_o), .ack_o(flash_ack_i), .rvalid_o(flash_rvalid_i),
    .rdata_o(flash_rdata_i));
  task automatic step(int n = 1);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : step
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("errors=%0d compared=%0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Each flash op and download word meets the oldest note
  always @(posedge mclk_i) begin
    if (flash_req_o && flash_ack_i) chk({flash_op_o, flash_block_o,
      flash_page_o}, q.size() ? q.pop_front() : '1);
    if (dl_valid_o) chk(dl_data_o, d.pop_front());
    if (flash_rvalid_i) d.push_back(flash_rdata_i);
  end
  task automatic acquire(bit edge_mode, logic [21:0] dat, logic [21:0] dir);
    q.push_back(dat);
    q.push_back(dir);
    gate_edge_store_start_i = edge_mode;
    gate_level_store_start_i = !edge_mode;
    step();
    gate_edge_store_start_i = 0;
    gate_level_store_start_i = 0;
    repeat (2 + $urandom % 3) begin
      gate_i = 1;
      repeat (6) begin
        pulse_i = $urandom;
        step();
      end
      gate_i = 0;
      step(6);
    end
    stop_i = 1;
    step();
    stop_i = 0;
    for (int i = 0; i < 400 && acq_active_o; i++) step();
    chk(acq_active_o, 0);
  endtask : acquire
  initial begin
    #100us;
    n_errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'h63d40026));
    step(3);
    resetn_i = 1;
    step();
    chk(current_label_o, 64'h646174615f303031);
    chk({acq_active_o, file_count_o}, 0);
    planned_sample_count_i = 20'hfffff;
    planned_sample_count_set_i = 1;
    step();
    planned_sample_count_set_i = 0;
    step();
    chk(planned_sample_count_o, PLAN_MAX);
    for (int s = 0; s < 4; s++) begin
      read_style_i = 2'(s);
      read_style_select_i = 1;
      step();
      read_style_select_i = 0;
      step();
      chk(read_style_o, s < 3 ? s : 2);
    end
    file_label_i = 64'h6c6f675f61616161;
    file_label_set_i = 1;
    step();
    file_label_set_i = 0;
    step();
    chk(current_label_o, 64'h6c6f675f61616161);
    acquire(0, {FOP_PROG, 12'h001, 8'h00}, {FOP_PROG, 12'h000, 8'h00});
    chk(file_count_o, 1);
    bad_block_i = 12'h002;
    bad_mark_i = 1;
    step();
    bad_mark_i = 0;
    acquire(1, {FOP_PROG, 12'h003, 8'h00}, {FOP_PROG, 12'h000, 8'h01});
    chk(file_count_o, 2);
    file_download_i = 1;
    step();
    file_download_i = 0;
    step(4);
    chk(dl_notfound_o, 1);
    q.push_back({FOP_READ, 12'h000, 8'h01});
    directory_query_i = 1;
    step();
    directory_query_i = 0;
    step(4);
    for (int i = 0; i < 300 && (flash_rd_o || flash_req_o); i++) step();
    step();
    chk(q.size() + d.size(), 0);
    test_done();
  end
endmodule : tb
